// file: rxof_defines.svh
/*
  Constants for the receive parallel output formatter: ternary strap
  codes, comma patterns, register offsets and reset values.
  Assumes it is included by bare name after `timescale.
*/
`ifndef RXOF_DEFINES_SVH
`define RXOF_DEFINES_SVH

// ****************************************************************
// Ternary strap codes (two wires per strap)
// ****************************************************************
`define RXOF_TERN_LOW 2'h0
`define RXOF_TERN_MID 2'h1
`define RXOF_TERN_HIGH 2'h2
`define RXOF_TERN_FLOAT 2'h3

// ****************************************************************
// Character fields
// ****************************************************************
`define RXOF_COMMA_POS 7'h1f
`define RXOF_COMMA_NEG 7'h60
`define RXOF_MODE_WEIGHT 4'h3

// ****************************************************************
// Register map and reset values
// ****************************************************************
`define RXOF_ADDR_STATUS 4'h0
`define RXOF_ADDR_MASK 4'h4
`define RXOF_ADDR_CONFIG 4'h8
`define RXOF_ADDR_OPMODE 4'hc
`define RXOF_EV_COMMA_A 0
`define RXOF_EV_COMMA_B 1
`define RXOF_EV_STRAP 2
`define RXOF_MASK_RST 3'h0
`define RXOF_ZERO8 8'h00

`endif

// file: rxof_pkg.sv
/*
  Types shared by the receive parallel output formatter.
  Assumes rxof_defines.svh is not needed here; widths are fixed.
*/
`default_nettype none

package rxof_pkg;

  // ****************************************************************
  // Complete registered state of the formatter
  // ****************************************************************
  typedef struct packed {
    logic [1:0][7:0] byte_r;
    logic [1:0][2:0] stat_r;
    logic [1:0] par_r;
    logic [1:0] par_oe_r;
    logic [3:0] op_mode_r;
    logic [5:0] strap_r;
    logic strap_ok_r;
    logic [2:0] ev_r;
    logic [2:0] mask_r;
    logic [7:0] rdata_r;
    logic irq_r;
  } rxof_state_t;

endpackage : rxof_pkg

`default_nettype wire

// file: rxof_formatter.sv
/*
  Receive parallel output formatter for two channels: output register,
  raw bypass, odd parity with enable, transmit mode decode, and a small
  event/interrupt register file.
  Assumes clk is the selected receive interface clock, straps arrive
  as two-wire ternary codes (code 3 = left open), and inputs are
  synchronous to clk.
*/
// Overview of operation
// [R1] Data and status change only after a rising edge of the selected clock.
// [R2] Decoder on (HIGH or MID): data bus carries decoded byte or special.
// [R3] Decoder bypassed: data bus carries top eight bits of raw character.
// [R4] Decoder bypassed: status bits one and zero carry raw low bits.
// [R5] Decoder bypassed: status bit two high while register holds a comma.
// [R6] Decoder on: all three status bits report receive character status.
// [R7] Parity setting not LOW: parity pin drives odd parity of data bus.
// [R8] Parity setting LOW: parity pin not driven (enable low).
// [R9] Two ternary transmit selects decode to one of nine modes.
// [R10] Straps are static LOW/MID/HIGH; open strap reads as MID.
// [R11] Host samples data, status and parity together as one word.
`timescale 1ns/100ps
`default_nettype none
`include "rxof_defines.svh"

module rxof_formatter (
  input wire logic clk,
  input wire logic rst,
  input wire logic [1:0] decoder_setting,
  input wire logic [1:0] parity_setting,
  input wire logic [1:0] transmit_operating_select_hi,
  input wire logic [1:0] transmit_operating_select_lo,
  input wire logic rx_char_valid_chan_a,
  input wire logic rx_char_valid_chan_b,
  input wire logic [7:0] rx_dec_byte_chan_a,
  input wire logic [7:0] rx_dec_byte_chan_b,
  input wire logic [2:0] rx_dec_status_chan_a,
  input wire logic [2:0] rx_dec_status_chan_b,
  input wire logic [9:0] rx_raw_char_chan_a,
  input wire logic [9:0] rx_raw_char_chan_b,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic irq,
  output logic [7:0] rx_byte_out_chan_a,
  output logic [7:0] rx_byte_out_chan_b,
  output logic [2:0] rx_status_out_chan_a,
  output logic [2:0] rx_status_out_chan_b,
  output logic rx_parity_out_chan_a,
  output logic rx_parity_out_chan_b,
  output logic rx_parity_oe_chan_a,
  output logic rx_parity_oe_chan_b,
  output logic [3:0] tx_mode
);

  // ****************************************************************
  // Strap resolution
  // ****************************************************************

  // An open strap floats to MID, so code 3 folds onto MID
  function automatic logic [1:0] tern_res(input logic [1:0] s);
    tern_res = (s == `RXOF_TERN_FLOAT) ? `RXOF_TERN_MID : s;
  endfunction : tern_res

  logic [1:0] dec_res;
  logic [1:0] par_res;
  logic bypass;
  logic par_en;
  logic [3:0] mode_dec;

  // Resolved settings used by every channel
  assign dec_res = tern_res(decoder_setting); // [R10]
  assign par_res = tern_res(parity_setting); // [R10]
  assign bypass = (dec_res == `RXOF_TERN_LOW);
  assign par_en = (par_res != `RXOF_TERN_LOW);
  // Nine modes: weight three on the upper select
  assign mode_dec = `RXOF_MODE_WEIGHT * {2'h0, tern_res(transmit_operating_select_hi)}
    + {2'h0, tern_res(transmit_operating_select_lo)}; // [R9]

  // ****************************************************************
  // Per-channel word formation
  // ****************************************************************
  rxof_pkg::rxof_state_t st, st_nxt;

  logic [1:0] ch_valid;
  logic [1:0][7:0] ch_dec_byte;
  logic [1:0][2:0] ch_dec_stat;
  logic [1:0][9:0] ch_raw;
  logic [1:0][7:0] ch_byte_nxt;
  logic [1:0][2:0] ch_stat_nxt;
  logic [1:0] ch_comma;

  // Gather the two channels so one loop serves both
  assign ch_valid = {rx_char_valid_chan_b, rx_char_valid_chan_a};
  assign ch_dec_byte = {rx_dec_byte_chan_b, rx_dec_byte_chan_a};
  assign ch_dec_stat = {rx_dec_status_chan_b, rx_dec_status_chan_a};
  assign ch_raw = {rx_raw_char_chan_b, rx_raw_char_chan_a};

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_ch
      // Comma sits in the first seven bits of the raw character
      assign ch_comma[gi] = (ch_raw[gi][9:3] == `RXOF_COMMA_POS) ||
        (ch_raw[gi][9:3] == `RXOF_COMMA_NEG);
      // New word only on a valid character, else hold
      always_comb begin
        ch_byte_nxt[gi] = st.byte_r[gi];
        ch_stat_nxt[gi] = st.stat_r[gi];
        if (ch_valid[gi]) begin // [R1]
          if (bypass) begin
            ch_byte_nxt[gi] = ch_raw[gi][9:2]; // [R3]
            ch_stat_nxt[gi] = {ch_comma[gi], ch_raw[gi][1:0]}; // [R4] [R5]
          end else begin
            ch_byte_nxt[gi] = ch_dec_byte[gi]; // [R2]
            ch_stat_nxt[gi] = ch_dec_stat[gi]; // [R6]
          end
        end
      end
    end
  endgenerate

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  logic [2:0] ev_set;
  logic [5:0] strap_now;

  assign strap_now = {tern_res(decoder_setting), tern_res(parity_setting),
    mode_dec[1:0]};

  // Events: comma presented in bypass, or a strap moved in operation
  assign ev_set[`RXOF_EV_COMMA_A] = ch_valid[0] && bypass && ch_comma[0];
  assign ev_set[`RXOF_EV_COMMA_B] = ch_valid[1] && bypass && ch_comma[1];
  assign ev_set[`RXOF_EV_STRAP] = st.strap_ok_r && (strap_now != st.strap_r) ||
    st.strap_ok_r && (mode_dec != st.op_mode_r); // [R10]

  // One process builds the whole next state
  always_comb begin
    st_nxt = st;
    st_nxt.byte_r = ch_byte_nxt;
    st_nxt.stat_r = ch_stat_nxt;
    // Parity follows the new data word so all three leave together
    st_nxt.par_r[0] = par_en & ~^ch_byte_nxt[0]; // [R7] [R11]
    st_nxt.par_r[1] = par_en & ~^ch_byte_nxt[1]; // [R7] [R11]
    st_nxt.par_oe_r = {par_en, par_en}; // [R7] [R8]
    st_nxt.op_mode_r = mode_dec; // [R9]
    st_nxt.strap_r = strap_now;
    st_nxt.strap_ok_r = 1'b1;
    // Write-one-to-clear; a same-cycle event wins over the clear
    if (reg_wr && (reg_addr == `RXOF_ADDR_STATUS)) begin
      st_nxt.ev_r = st.ev_r & ~reg_wdata[2:0];
    end
    st_nxt.ev_r = st_nxt.ev_r | ev_set;
    if (reg_wr && (reg_addr == `RXOF_ADDR_MASK)) begin
      st_nxt.mask_r = reg_wdata[2:0];
    end
    // Read data stands only in the cycle after the strobe
    st_nxt.rdata_r = `RXOF_ZERO8;
    if (reg_rd) begin
      unique case (reg_addr)
        `RXOF_ADDR_STATUS: st_nxt.rdata_r = {5'h00, st.ev_r};
        `RXOF_ADDR_MASK: st_nxt.rdata_r = {5'h00, st.mask_r};
        `RXOF_ADDR_CONFIG: st_nxt.rdata_r = {4'h0, dec_res, par_res};
        `RXOF_ADDR_OPMODE: st_nxt.rdata_r = {4'h0, st.op_mode_r};
        default: st_nxt.rdata_r = `RXOF_ZERO8;
      endcase
    end
    // Level interrupt from the updated status and mask
    st_nxt.irq_r = |(st_nxt.ev_r & st_nxt.mask_r);
  end

  // ****************************************************************
  // State register
  // ****************************************************************

  // Synchronous reset clears the word; parity pins start undriven
  always_ff @(posedge clk) begin
    if (rst) begin
      st <= '0;
      st.mask_r <= `RXOF_MASK_RST;
    end else begin
      st <= st_nxt; // [R1]
    end
  end

  // ****************************************************************
  // Outputs, all straight from the state register
  // ****************************************************************
  assign rx_byte_out_chan_a = st.byte_r[0];
  assign rx_byte_out_chan_b = st.byte_r[1];
  assign rx_status_out_chan_a = st.stat_r[0];
  assign rx_status_out_chan_b = st.stat_r[1];
  assign rx_parity_out_chan_a = st.par_r[0];
  assign rx_parity_out_chan_b = st.par_r[1];
  assign rx_parity_oe_chan_a = st.par_oe_r[0];
  assign rx_parity_oe_chan_b = st.par_oe_r[1];
  assign tx_mode = st.op_mode_r;
  assign reg_rdata = st.rdata_r;
  assign irq = st.irq_r;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  logic past_ok;

  // Suppress checks that look back across reset
  always_ff @(posedge clk) begin
    if (rst) begin
      past_ok <= 1'b0;
    end else begin
      past_ok <= 1'b1;
    end
  end

  // Word holds while no character arrives, on both channels
  AST_HOLD_IDLE: assert property ( // [R1]
    past_ok && !rx_char_valid_chan_a && !rx_char_valid_chan_b |=>
      $stable(rx_byte_out_chan_a) && $stable(rx_status_out_chan_a) &&
      $stable(rx_byte_out_chan_b) && $stable(rx_status_out_chan_b))
    else $error("output word changed without a character");

  // Decoded byte appears one edge after it is offered
  AST_DEC_BYTE: assert property ( // [R2]
    rx_char_valid_chan_a && !bypass |=>
      rx_byte_out_chan_a == $past(rx_dec_byte_chan_a))
    else $error("decoded byte not presented");

  // Bypass: upper eight raw bits on the data bus
  AST_RAW_HIGH: assert property ( // [R3]
    rx_char_valid_chan_b && bypass |=>
      rx_byte_out_chan_b == $past(rx_raw_char_chan_b[9:2]))
    else $error("raw upper bits not presented");

  // Bypass: two low raw bits on status one and zero
  AST_RAW_LOW: assert property ( // [R4]
    rx_char_valid_chan_a && bypass |=>
      rx_status_out_chan_a[1:0] == $past(rx_raw_char_chan_a[1:0]))
    else $error("raw low bits not on status");

  // Bypass: status two tracks comma of the held character
  AST_COMMA_FLAG: assert property ( // [R5]
    rx_char_valid_chan_a && bypass |=>
      rx_status_out_chan_a[2] == $past(ch_comma[0]))
    else $error("comma flag wrong");

  // Decoder on: full status word from the decoder
  AST_DEC_STAT: assert property ( // [R6]
    rx_char_valid_chan_b && !bypass |=>
      rx_status_out_chan_b == $past(rx_dec_status_chan_b))
    else $error("decoder status not presented");

  // Driven parity makes the nine bits odd
  AST_ODD_PARITY: assert property ( // [R7]
    rx_parity_oe_chan_a |-> ^{rx_byte_out_chan_a, rx_parity_out_chan_a})
    else $error("parity not odd");

  // Parity setting LOW releases the pin on the next edge
  AST_PARITY_OFF: assert property ( // [R8]
    parity_setting == `RXOF_TERN_LOW |=> !rx_parity_oe_chan_a && !rx_parity_oe_chan_b)
    else $error("parity pin driven while disabled");

  // Mode index stays within the nine legal values
  AST_MODE_RANGE: assert property ( // [R9]
    past_ok |-> tx_mode <= 4'h8)
    else $error("transmit mode out of range");

  // Open straps behave as MID: decoder on, parity on
  AST_OPEN_IS_MID: assert property ( // [R10]
    decoder_setting == `RXOF_TERN_FLOAT && parity_setting == `RXOF_TERN_FLOAT &&
    rx_char_valid_chan_a |=> rx_byte_out_chan_a == $past(rx_dec_byte_chan_a) &&
      rx_parity_oe_chan_a)
    else $error("open strap not read as MID");

  // Parity and data leave together in one word
  AST_WORD_TOGETHER: assert property ( // [R11]
    rx_char_valid_chan_b && par_en |=> ##0 rx_parity_oe_chan_b &&
      ^{rx_byte_out_chan_b, rx_parity_out_chan_b})
    else $error("parity not aligned to data");

  // Interrupt level follows unmasked sticky status
  AST_IRQ_LEVEL: assert property (
    past_ok |-> irq == |(st.ev_r & st.mask_r))
    else $error("interrupt level mismatch");

  // Channel B decoded byte, mirror of channel A
  AST_DEC_BYTE_B: assert property ( // [R2]
    rx_char_valid_chan_b && !bypass |=>
      rx_byte_out_chan_b == $past(rx_dec_byte_chan_b))
    else $error("decoded byte not presented on channel B");

  // Channel A bypass: upper eight raw bits on the data bus
  AST_RAW_HIGH_A: assert property ( // [R3]
    rx_char_valid_chan_a && bypass |=>
      rx_byte_out_chan_a == $past(rx_raw_char_chan_a[9:2]))
    else $error("raw upper bits not presented on channel A");

  // Channel B bypass: two low raw bits on status one and zero
  AST_RAW_LOW_B: assert property ( // [R4]
    rx_char_valid_chan_b && bypass |=>
      rx_status_out_chan_b[1:0] == $past(rx_raw_char_chan_b[1:0]))
    else $error("raw low bits not on status of channel B");

  // Channel B bypass: status two tracks comma of the held character
  AST_COMMA_FLAG_B: assert property ( // [R5]
    rx_char_valid_chan_b && bypass |=>
      rx_status_out_chan_b[2] == $past(ch_comma[1]))
    else $error("comma flag wrong on channel B");

  // Channel A decoder on: full status word from the decoder
  AST_DEC_STAT_A: assert property ( // [R6]
    rx_char_valid_chan_a && !bypass |=>
      rx_status_out_chan_a == $past(rx_dec_status_chan_a))
    else $error("decoder status not presented on channel A");

  // Channel B driven parity makes the nine bits odd
  AST_ODD_PARITY_B: assert property ( // [R7]
    rx_parity_oe_chan_b |-> ^{rx_byte_out_chan_b, rx_parity_out_chan_b})
    else $error("parity not odd on channel B");

  // Released pins keep their output low so no stale parity lingers
  AST_PARITY_QUIET: assert property ( // [R8]
    !rx_parity_oe_chan_a && !rx_parity_oe_chan_b |-> !rx_parity_out_chan_a && !rx_parity_out_chan_b)
    else $error("parity output active while released");

  // A same-cycle clear never beats a new event
  AST_STICKY_SET: assert property (
    (ev_set != 3'h0) |=> (st.ev_r & $past(ev_set)) == $past(ev_set))
    else $error("event lost against a clear");

  // Read data returns to zero when no read was asked for
  AST_RDATA_IDLE: assert property (
    !reg_rd |=> reg_rdata == `RXOF_ZERO8)
    else $error("read data outside its cycle");

  // Main scenarios
  COV_BYPASS_COMMA: cover property (
    rx_char_valid_chan_a && bypass && ch_comma[0] ##1 irq);
  COV_DECODED: cover property (
    rx_char_valid_chan_b && !bypass ##1 rx_parity_oe_chan_b);
  COV_READ_CLEAR: cover property (
    reg_wr && reg_addr == `RXOF_ADDR_STATUS && st.ev_r != 3'h0 ##2 reg_rd);
  COV_OPEN_STRAPS: cover property (
    decoder_setting == `RXOF_TERN_FLOAT && parity_setting == `RXOF_TERN_FLOAT && rx_char_valid_chan_a);
  COV_PARITY_RELEASE: cover property (
    rx_parity_oe_chan_a ##1 !rx_parity_oe_chan_a);

endmodule : rxof_formatter

`default_nettype wire

// file: rxof_host_model.sv
/*
  Host receive logic model: captures data, status and parity of both
  channels as one word on every rising edge of the receive clock.
  Assumes the parity pin has no pull; a released pin wanders.
*/
`timescale 1ns/100ps
`default_nettype none

module rxof_host_model (
  input wire logic clk,
  input wire logic [1:0][7:0] byte_in,
  input wire logic [1:0][2:0] stat_in,
  input wire logic [1:0] par_in,
  input wire logic [1:0] par_oe,
  output logic [1:0][7:0] cap_byte,
  output logic [1:0][2:0] cap_stat,
  output logic [1:0] cap_par
);
  logic [1:0] pin_last = 2'h0;
  logic [1:0] pin;

  // Released pin shows the inverse of its last level, so a stale value never passes
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      pin[i] = par_oe[i] ? par_in[i] : ~pin_last[i];
    end
  end

  // One registered word every clock, all fields on the same edge
  always @(posedge clk) begin
    cap_byte <= byte_in;
    cap_stat <= stat_in;
    cap_par <= pin;
    pin_last <= pin;
  end
endmodule : rxof_host_model

`default_nettype wire

// file: tb_rx_parallel_output_formatter.sv
/*
  Self-checking bench for the receive output formatter.
  Assumes one 250 MHz clock standing for the selected receive clock.
*/
`timescale 1ns/100ps
`default_nettype none
`include "rxof_defines.svh"

module tb_rx_parallel_output_formatter;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [1:0] dec_set = `RXOF_TERN_LOW;
  logic [1:0] par_set = `RXOF_TERN_HIGH;
  logic [1:0] tx_hi = 2'h0;
  logic [1:0] tx_lo = 2'h0;
  logic [1:0] vld = 2'h0;
  logic [1:0][7:0] dbyte = '0;
  logic [1:0][2:0] dstat = '0;
  logic [1:0][9:0] raw = '0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic irq;
  logic [3:0] tx_mode;
  wire logic [1:0][7:0] ob;
  wire logic [1:0][2:0] os;
  wire logic [1:0] op;
  wire logic [1:0] oe;
  logic [1:0][7:0] cap_byte;
  logic [1:0][2:0] cap_stat;
  logic [1:0] cap_par;
  int err_total = 0;
  int total_checks = 0;

  // 4 ns period
  always #2 clk = ~clk;

  rxof_formatter uut (.clk(clk), .rst(rst), .decoder_setting(dec_set), .parity_setting(par_set),
    .transmit_operating_select_hi(tx_hi), .transmit_operating_select_lo(tx_lo),
    .rx_char_valid_chan_a(vld[0]), .rx_char_valid_chan_b(vld[1]),
    .rx_dec_byte_chan_a(dbyte[0]), .rx_dec_byte_chan_b(dbyte[1]),
    .rx_dec_status_chan_a(dstat[0]), .rx_dec_status_chan_b(dstat[1]),
    .rx_raw_char_chan_a(raw[0]), .rx_raw_char_chan_b(raw[1]),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .irq(irq), .rx_byte_out_chan_a(ob[0]), .rx_byte_out_chan_b(ob[1]),
    .rx_status_out_chan_a(os[0]), .rx_status_out_chan_b(os[1]),
    .rx_parity_out_chan_a(op[0]), .rx_parity_out_chan_b(op[1]),
    .rx_parity_oe_chan_a(oe[0]), .rx_parity_oe_chan_b(oe[1]), .tx_mode(tx_mode));

  rxof_host_model host (.clk(clk), .byte_in(ob), .stat_in(os), .par_in(op), .par_oe(oe),
    .cap_byte(cap_byte), .cap_stat(cap_stat), .cap_par(cap_par));

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : close_out

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : reg_write

  // Read data stands only in the cycle after the strobe
  task automatic reg_check(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk("rdata", {8'h00, reg_rdata}, {8'h00, e});
  endtask : reg_check

  task automatic wait_irq(input logic lvl);
    int n;
    n = 0;
    while (irq !== lvl && n < 8) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk("irq", {15'h0, irq}, {15'h0, lvl});
    if (irq !== lvl) begin
      close_out();
    end
  endtask : wait_irq

  // One character on both channels, then inputs scrambled with valid low
  task automatic send(input logic [1:0][9:0] r, input logic [1:0][7:0] d, input logic [1:0][2:0] s);
    logic [7:0] eb;
    logic [2:0] es;
    logic c;
    logic byp;
    @(posedge clk);
    // Strap set just before the call is only visible after this edge
    byp = (dec_set == `RXOF_TERN_LOW);
    raw <= r;
    dbyte <= d;
    dstat <= s;
    vld <= 2'h3;
    @(posedge clk);
    vld <= 2'h0;
    raw <= ~r;
    dbyte <= ~d;
    dstat <= ~s;
    @(posedge clk);
    #1;
    for (int i = 0; i < 2; i++) begin
      c = (r[i][9:3] == `RXOF_COMMA_POS) || (r[i][9:3] == `RXOF_COMMA_NEG);
      eb = byp ? r[i][9:2] : d[i];
      es = byp ? {c, r[i][1:0]} : s[i];
      chk("byte", {8'h00, ob[i]}, {8'h00, eb});
      chk("status", {13'h0, os[i]}, {13'h0, es});
      chk("host_byte", {8'h00, cap_byte[i]}, {8'h00, eb});
      chk("host_status", {13'h0, cap_stat[i]}, {13'h0, es});
      if (par_set != `RXOF_TERN_LOW) begin
        chk("parity_oe", {15'h0, oe[i]}, 16'h0001);
        chk("host_parity", {15'h0, cap_par[i]}, {15'h0, ~^eb});
      end else begin
        chk("parity_oe", {15'h0, oe[i]}, 16'h0000);
      end
    end
  endtask : send

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_txmode;
    logic [1:0] v[4];
    int lv[4];
    v = '{`RXOF_TERN_LOW, `RXOF_TERN_MID, `RXOF_TERN_HIGH, `RXOF_TERN_FLOAT};
    lv = '{0, 1, 2, 1};
    for (int h = 0; h < 4; h++) begin
      for (int l = 0; l < 4; l++) begin
        @(posedge clk);
        tx_hi <= v[h];
        tx_lo <= v[l];
        repeat (2) @(posedge clk);
        #1;
        chk("tx_mode", {12'h0, tx_mode}, 16'(3 * lv[h] + lv[l]));
      end
    end
  endtask : t_txmode

  // Comma on channel B only raises its sticky bit; the mask gates the interrupt
  task automatic t_events;
    reg_check(`RXOF_ADDR_STATUS, 8'h07);
    reg_check(`RXOF_ADDR_CONFIG, 8'h02);
    reg_check(`RXOF_ADDR_OPMODE, 8'h04);
    reg_write(`RXOF_ADDR_STATUS, 8'h07);
    reg_check(`RXOF_ADDR_STATUS, 8'h00);
    send('{10'h306, 10'h2a5}, '{8'h00, 8'h00}, '{3'h0, 3'h0});
    reg_check(`RXOF_ADDR_STATUS, 8'h02);
    wait_irq(1'b0);
    reg_write(`RXOF_ADDR_MASK, 8'h02);
    reg_check(`RXOF_ADDR_MASK, 8'h02);
    wait_irq(1'b1);
    reg_write(`RXOF_ADDR_STATUS, 8'h02);
    wait_irq(1'b0);
    reg_check(4'h2, 8'h00);
  endtask : t_events

  task automatic t_decoder;
    logic [1:0] v[3];
    v = '{`RXOF_TERN_MID, `RXOF_TERN_HIGH, `RXOF_TERN_FLOAT};
    for (int i = 0; i < 3; i++) begin
      @(posedge clk);
      dec_set <= v[i];
      par_set <= v[i];
      send('{10'h0f9, 10'h306}, '{8'h5a, 8'hbc}, '{3'h5, 3'h2});
    end
  endtask : t_decoder

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk("reset_oe", {14'h0, oe}, 16'h0000);
    chk("reset_byte", {8'h00, ob[0]}, 16'h0000);
    reg_check(`RXOF_ADDR_MASK, {5'h00, `RXOF_MASK_RST});
    t_txmode();
    send('{10'h306, 10'h0f9}, '{8'h00, 8'h00}, '{3'h0, 3'h0});
    send('{10'h2a5, 10'h3ff}, '{8'h00, 8'h00}, '{3'h0, 3'h0});
    t_events();
    t_decoder();
    @(posedge clk);
    par_set <= `RXOF_TERN_LOW;
    send('{10'h155, 10'h0aa}, '{8'h81, 8'h7e}, '{3'h1, 3'h3});
    close_out();
  end
endmodule : tb_rx_parallel_output_formatter

`default_nettype wire
